// ---- rtl/fpopd_defs.vh ----
// Constants for the floating-point operand pairing and dispatch block
// Contract
// - Double pair: bits 4:1 with 0 and 1
// - Extended group: bits 4:2 with 00,01,10
// - Arithmetic ops return five-bit exception vector
// - Compare ops return two-bit condition code
// - Completion bit only when unit finished
// - Int-to-float reads single second source register
// - Float-to-int gathers single, pair or group
// - Six format conversions gather by source precision
// - Square root uses second source only
`ifndef FPOPD_DEFS_VH
`define FPOPD_DEFS_VH
// Operation codes on the issue port
`define FPOPD_OP_NONE 5'h00
`define FPOPD_OP_I2S 5'h01
`define FPOPD_OP_I2D 5'h02
`define FPOPD_OP_I2X 5'h03
`define FPOPD_OP_S2I 5'h04
`define FPOPD_OP_D2I 5'h05
`define FPOPD_OP_X2I 5'h06
`define FPOPD_OP_S2D 5'h07
`define FPOPD_OP_S2X 5'h08
`define FPOPD_OP_D2S 5'h09
`define FPOPD_OP_D2X 5'h0A
`define FPOPD_OP_X2S 5'h0B
`define FPOPD_OP_X2D 5'h0C
`define FPOPD_OP_RTS 5'h0D
`define FPOPD_OP_RTD 5'h0E
`define FPOPD_OP_RTX 5'h0F
`define FPOPD_OP_CMP 5'h10
// Precision codes
`define FPOPD_PR_INT 2'h0
`define FPOPD_PR_SGL 2'h1
`define FPOPD_PR_DBL 2'h2
`define FPOPD_PR_EXT 2'h3
// Read sequencer states
`define FPOPD_ST_IDLE 2'h0
`define FPOPD_ST_READ 2'h1
`define FPOPD_ST_EXEC 2'h2
`define FPOPD_ST_WRITE 2'h3
// Reset values
`define FPOPD_RST_EXC 5'h00
`define FPOPD_RST_FCC 2'h0
`endif

// ---- rtl/fpopd_regfile.v ----
// Floating-point register file, 32 words, registered read
`timescale 1ns/1ps
`default_nettype none
module fpopd_regfile #(
	parameter WIDTH = 32,
	parameter DEPTH = 32
) (
	// Clock
	input wire clk_i,
	// Read port
	input wire [4:0] raddr_i,
	output reg [WIDTH-1:0] rdata_o,
	// Write port
	input wire we_i,
	input wire [4:0] waddr_i,
	input wire [WIDTH-1:0] wdata_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words

	// Write, and registered read of the word held before this edge's write
	always @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule
`default_nettype wire

// ---- rtl/fpopd_top.v ----
// Operand gathering, dispatch and result return for conversion and root ops
`timescale 1ns/1ps
`default_nettype none
`include "fpopd_defs.vh"
module fpopd_top (
	// Clock and reset
	input wire MCLK_I,
	input wire RST_I,
	// Issue port from the integer unit
	input wire ISSUE_I,
	input wire [4:0] OP_I,
	input wire [4:0] RS2_I,
	input wire [4:0] RD_I,
	output reg BUSY_O,
	// Arithmetic unit request
	output reg AU_REQ_O,
	output reg [4:0] AU_OP_O,
	output reg [95:0] AU_SRC_O,
	// Arithmetic unit answer
	input wire AU_DONE_I,
	input wire [95:0] AU_RES_I,
	input wire [4:0] AU_EXC_I,
	input wire [1:0] AU_FCC_I,
	input wire AU_CMPL_I,
	// Result return to the integer unit
	output reg DONE_O,
	output reg [95:0] RESULT_O,
	output reg [4:0] EXC_O,
	output reg [1:0] FCC_O,
	output reg CMPL_O,
	// Preload write port into the register file
	input wire LOAD_WE_I,
	input wire [4:0] LOAD_ADDR_I,
	input wire [31:0] LOAD_DATA_I
);
	reg [1:0] state_q; // Sequencer state
	reg [4:0] op_q; // Latched operation
	reg [4:0] rs2_q; // Latched second source specifier
	reg [4:0] rd_q; // Latched destination specifier
	reg [1:0] spr_q; // Source precision
	reg [1:0] dpr_q; // Destination precision
	reg [1:0] idx_q; // Word counter
	reg rvalid_q; // Read data valid this cycle
	reg [1:0] ridx_q; // Index of word in flight
	reg [95:0] gath_q; // Gathered source words
	reg [95:0] res_q; // Latched result
	reg [1:0] widx_q; // Write-back word index
	reg [1:0] wcnt_q; // Index of the last word to write back
	reg [1:0] spr_d;
	reg [1:0] dpr_d;
	reg [4:0] raddr; // Register read address
	reg [4:0] waddr; // Register write address
	reg [31:0] wdata; // Register write data
	wire [31:0] rdata; // Register read data
	wire wb_en; // Write-back strobe

	// Precisions for each operation
	always @* begin
		spr_d = `FPOPD_PR_SGL;
		dpr_d = `FPOPD_PR_SGL;
		case (OP_I)
			`FPOPD_OP_I2S: {spr_d, dpr_d} = {`FPOPD_PR_INT, `FPOPD_PR_SGL};
			`FPOPD_OP_I2D: {spr_d, dpr_d} = {`FPOPD_PR_INT, `FPOPD_PR_DBL};
			`FPOPD_OP_I2X: {spr_d, dpr_d} = {`FPOPD_PR_INT, `FPOPD_PR_EXT};
			`FPOPD_OP_S2I: {spr_d, dpr_d} = {`FPOPD_PR_SGL, `FPOPD_PR_INT};
			`FPOPD_OP_D2I: {spr_d, dpr_d} = {`FPOPD_PR_DBL, `FPOPD_PR_INT};
			`FPOPD_OP_X2I: {spr_d, dpr_d} = {`FPOPD_PR_EXT, `FPOPD_PR_INT};
			`FPOPD_OP_S2D: {spr_d, dpr_d} = {`FPOPD_PR_SGL, `FPOPD_PR_DBL};
			`FPOPD_OP_S2X: {spr_d, dpr_d} = {`FPOPD_PR_SGL, `FPOPD_PR_EXT};
			`FPOPD_OP_D2S: {spr_d, dpr_d} = {`FPOPD_PR_DBL, `FPOPD_PR_SGL};
			`FPOPD_OP_D2X: {spr_d, dpr_d} = {`FPOPD_PR_DBL, `FPOPD_PR_EXT};
			`FPOPD_OP_X2S: {spr_d, dpr_d} = {`FPOPD_PR_EXT, `FPOPD_PR_SGL};
			`FPOPD_OP_X2D: {spr_d, dpr_d} = {`FPOPD_PR_EXT, `FPOPD_PR_DBL};
			`FPOPD_OP_RTS: {spr_d, dpr_d} = {`FPOPD_PR_SGL, `FPOPD_PR_SGL};
			`FPOPD_OP_RTD: {spr_d, dpr_d} = {`FPOPD_PR_DBL, `FPOPD_PR_DBL};
			`FPOPD_OP_RTX: {spr_d, dpr_d} = {`FPOPD_PR_EXT, `FPOPD_PR_EXT};
			default: {spr_d, dpr_d} = {`FPOPD_PR_SGL, `FPOPD_PR_SGL}; // Compare: no write
		endcase
	end

	// Source read address by precision alignment
	always @* begin
		case (spr_q)
			`FPOPD_PR_DBL: raddr = {rs2_q[4:1], idx_q[0]};
			`FPOPD_PR_EXT: raddr = {rs2_q[4:2], idx_q};
			default: raddr = rs2_q;
		endcase
	end

	// Destination write address by precision alignment
	always @* begin
		case (dpr_q)
			`FPOPD_PR_DBL: waddr = {rd_q[4:1], widx_q[0]};
			`FPOPD_PR_EXT: waddr = {rd_q[4:2], widx_q};
			default: waddr = rd_q;
		endcase
		case (widx_q)
			2'h0: wdata = res_q[95:64];
			2'h1: wdata = res_q[63:32];
			default: wdata = res_q[31:0];
		endcase
	end

	// Write-back only for completed non-compare results
	assign wb_en = (state_q == `FPOPD_ST_WRITE);

	fpopd_regfile #(
		.WIDTH(32),
		.DEPTH(32)
	) u_regfile (
		.clk_i(MCLK_I),
		.raddr_i(raddr),
		.rdata_o(rdata),
		.we_i(wb_en | LOAD_WE_I),
		.waddr_i(wb_en ? waddr : LOAD_ADDR_I),
		.wdata_i(wb_en ? wdata : LOAD_DATA_I)
	);

	// Sequencer: gather, dispatch, collect, write back
	always @(posedge MCLK_I) begin
		if (RST_I) begin
			state_q <= `FPOPD_ST_IDLE;
			op_q <= `FPOPD_OP_NONE;
			rs2_q <= 5'h00;
			rd_q <= 5'h00;
			spr_q <= `FPOPD_PR_SGL;
			dpr_q <= `FPOPD_PR_SGL;
			idx_q <= 2'h0;
			rvalid_q <= 1'b0;
			ridx_q <= 2'h0;
			gath_q <= 96'h0;
			res_q <= 96'h0;
			widx_q <= 2'h0;
			wcnt_q <= 2'h0;
			BUSY_O <= 1'b0;
			AU_REQ_O <= 1'b0;
			AU_OP_O <= `FPOPD_OP_NONE;
			AU_SRC_O <= 96'h0;
			DONE_O <= 1'b0;
			RESULT_O <= 96'h0;
			EXC_O <= `FPOPD_RST_EXC;
			FCC_O <= `FPOPD_RST_FCC;
			CMPL_O <= 1'b0;
		end else begin
			DONE_O <= 1'b0;
			AU_REQ_O <= 1'b0;
			rvalid_q <= 1'b0;
			case (state_q)
				`FPOPD_ST_IDLE: begin
					// Accept a new operation
					if (ISSUE_I) begin
						op_q <= OP_I;
						rs2_q <= RS2_I;
						rd_q <= RD_I;
						spr_q <= spr_d;
						dpr_q <= dpr_d;
						idx_q <= 2'h0;
						gath_q <= 96'h0;
						BUSY_O <= 1'b1;
						state_q <= `FPOPD_ST_READ;
					end
				end
				`FPOPD_ST_READ: begin
					// Issue word reads, capture registered data
					if (!rvalid_q || ridx_q != idx_q) begin
						rvalid_q <= 1'b1;
						ridx_q <= idx_q;
					end
					if (rvalid_q) begin
						case (ridx_q)
							2'h0: gath_q[95:64] <= rdata;
							2'h1: gath_q[63:32] <= rdata;
							default: gath_q[31:0] <= rdata;
						endcase
						if ((spr_q == `FPOPD_PR_DBL && ridx_q == 2'h1) ||
							(spr_q == `FPOPD_PR_EXT && ridx_q == 2'h2) ||
							(spr_q != `FPOPD_PR_DBL && spr_q != `FPOPD_PR_EXT)) begin
							state_q <= `FPOPD_ST_EXEC;
							AU_REQ_O <= 1'b1;
							AU_OP_O <= op_q;
							case (ridx_q)
								2'h0: AU_SRC_O <= {rdata, 64'h0};
								2'h1: AU_SRC_O <= {gath_q[95:64], rdata, 32'h0};
								default: AU_SRC_O <= {gath_q[95:32], rdata};
							endcase
						end else begin
							idx_q <= ridx_q + 2'h1;
							rvalid_q <= 1'b0;
						end
					end
				end
				`FPOPD_ST_EXEC: begin
					// Collect the arithmetic unit answer
					if (AU_DONE_I) begin
						res_q <= AU_RES_I;
						RESULT_O <= AU_RES_I;
						EXC_O <= (op_q == `FPOPD_OP_CMP) ? `FPOPD_RST_EXC : AU_EXC_I;
						FCC_O <= (op_q == `FPOPD_OP_CMP) ? AU_FCC_I : `FPOPD_RST_FCC;
						CMPL_O <= AU_CMPL_I;
						widx_q <= 2'h0;
						case (dpr_q)
							`FPOPD_PR_DBL: wcnt_q <= 2'h1;
							`FPOPD_PR_EXT: wcnt_q <= 2'h2;
							default: wcnt_q <= 2'h0;
						endcase
						if (AU_CMPL_I && op_q != `FPOPD_OP_CMP) begin
							state_q <= `FPOPD_ST_WRITE;
						end else begin
							DONE_O <= 1'b1;
							BUSY_O <= 1'b0;
							state_q <= `FPOPD_ST_IDLE;
						end
					end
				end
				`FPOPD_ST_WRITE: begin
					// Write result words to the destination group
					if (widx_q == wcnt_q) begin
						DONE_O <= 1'b1;
						BUSY_O <= 1'b0;
						state_q <= `FPOPD_ST_IDLE;
					end else begin
						widx_q <= widx_q + 2'h1;
					end
				end
				default: begin
					state_q <= `FPOPD_ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- verif/fpopd_fn.svh ----
// Source word count for each opcode, shared by bench and checker
function automatic [1:0] nw(input [4:0] o);
	case (o)
		`FPOPD_OP_D2I, `FPOPD_OP_D2S, `FPOPD_OP_D2X, `FPOPD_OP_RTD: nw = 2'h2;
		`FPOPD_OP_X2I, `FPOPD_OP_X2S, `FPOPD_OP_X2D, `FPOPD_OP_RTX: nw = 2'h3;
		default: nw = 2'h1;
	endcase
endfunction

// ---- verif/fpopd_chk.sv ----
// Checker for gather timing and result return
`timescale 1ns/1ps
`default_nettype none
`include "fpopd_defs.vh"
module fpopd_chk (
	// Watched ports
	input wire MCLK_I, RST_I, ISSUE_I, BUSY_O, AU_REQ_O, AU_DONE_I, AU_CMPL_I, DONE_O, CMPL_O,
	input wire [4:0] OP_I, AU_OP_O, AU_EXC_I, EXC_O,
	input wire [1:0] AU_FCC_I, FCC_O,
	input wire [95:0] AU_SRC_O
);
	`include "fpopd_fn.svh"
	reg [4:0] op_q; // Opcode in flight
	reg wait_q; // Unit answer pending
	wire cmp_w = op_q == `FPOPD_OP_CMP;
	wire ans_w = wait_q && AU_DONE_I;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	// Track opcode and pending answer
	always @(posedge MCLK_I) begin
		if (RST_I) begin
			op_q <= 5'h00;
			wait_q <= 1'b0;
		end else begin
			if (ISSUE_I && !BUSY_O) begin
				op_q <= OP_I;
			end
			if (AU_REQ_O) begin
				wait_q <= 1'b1;
			end else if (AU_DONE_I) begin
				wait_q <= 1'b0;
			end
		end
	end
	a_req_single: assert property (ISSUE_I && !BUSY_O && nw(OP_I) == 2'h1 |->
		##1 !AU_REQ_O [*2] ##1 AU_REQ_O) else $error("single gather late");
	a_req_double: assert property (ISSUE_I && !BUSY_O && nw(OP_I) == 2'h2 |-> ##5 AU_REQ_O)
		else $error("pair gather late");
	a_req_ext: assert property (ISSUE_I && !BUSY_O && nw(OP_I) == 2'h3 |-> ##7 AU_REQ_O)
		else $error("group gather late");
	a_op_pass: assert property (AU_REQ_O |-> AU_OP_O == op_q) else $error("opcode lost");
	a_single_pad: assert property (AU_REQ_O && nw(op_q) == 2'h1 |-> AU_SRC_O[63:0] == 64'h0)
		else $error("single source not padded");
	a_pair_pad: assert property (AU_REQ_O && nw(op_q) == 2'h2 |-> AU_SRC_O[31:0] == 32'h0)
		else $error("pair source not padded");
	a_exc_pass: assert property (ans_w && !cmp_w |=> EXC_O == $past(AU_EXC_I) && FCC_O == 2'h0)
		else $error("exception vector wrong");
	a_fcc_pass: assert property (ans_w && cmp_w |=> FCC_O == $past(AU_FCC_I) && EXC_O == 5'h00)
		else $error("condition code wrong");
	a_cmpl_pass: assert property (ans_w |=> CMPL_O == $past(AU_CMPL_I))
		else $error("completion bit wrong");
	a_done_bound: assert property (ans_w |-> ##[1:4] DONE_O) else $error("no done");
	c_wb: cover property (DONE_O && CMPL_O);
	c_ext: cover property (AU_REQ_O && nw(op_q) == 2'h3);
	c_cmp: cover property (DONE_O && cmp_w);
endmodule
bind fpopd_top fpopd_chk u_fpopd_chk (.MCLK_I, .RST_I, .ISSUE_I, .OP_I, .BUSY_O, .AU_REQ_O,
	.AU_OP_O, .AU_SRC_O, .AU_DONE_I, .AU_EXC_I, .AU_FCC_I, .AU_CMPL_I, .DONE_O, .EXC_O, .FCC_O,
	.CMPL_O);
`default_nettype wire

// ---- verif/fpopd_au_model.sv ----
// Arithmetic unit stand-in answering gather requests
`timescale 1ns/1ps
`default_nettype none
module fpopd_au_model (
	// Clock, reset and request
	input wire clk_i, rst_i, req_i, cmpl_i,
	input wire [4:0] op_i,
	input wire [3:0] dly_i,
	input wire [95:0] src_i,
	// Answer lines
	output wire done_o, cmpl_o,
	output wire [95:0] res_o,
	output wire [4:0] exc_o,
	output wire [1:0] fcc_o
);
	logic [3:0] cnt_q = 4'h0; // Cycles left to answer
	logic [95:0] s_q = 96'h0; // Latched operands
	logic [4:0] o_q = 5'h00; // Latched opcode
	// Answer after the set delay
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
		end else if (req_i) begin
			cnt_q <= dly_i;
			s_q <= src_i;
			o_q <= op_i;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
	// exc_o, fcc_o and cmpl_o carry inverted junk outside the answer cycle; res_o is inverted in it
	assign done_o = cnt_q == 4'h1;
	assign res_o = done_o ? ~s_q : s_q;
	assign exc_o = done_o ? o_q : ~o_q;
	assign fcc_o = done_o ? s_q[65:64] : ~s_q[65:64];
	assign cmpl_o = done_o ? cmpl_i : !cmpl_i;
endmodule
`default_nettype wire

// ---- verif/fpop_operand_pairing_dispatch_bench.sv ----
// Self-checking bench for operand gathering and result return
`timescale 1ns/1ps
`default_nettype none
`include "fpopd_defs.vh"
module fpop_operand_pairing_dispatch_bench;
	`include "fpopd_fn.svh"
	logic clk = 1'b0, rst = 1'b1, issue = 1'b0, we = 1'b0, mcmpl = 1'b0;
	logic [4:0] op = 5'h00, rs2 = 5'h00, rd = 5'h00, la = 5'h00, aop, exc, aexc;
	logic [31:0] ld = 32'h0;
	logic [31:0] mem [32]; // Expected register contents
	logic [3:0] dly = 4'h1;
	logic [95:0] src, res, ares;
	logic [1:0] fcc, afcc;
	wire busy, req, done, cm, adone, acmpl;
	int fail_count = 0, checks_done = 0;
	always #5 clk = ~clk;
	fpopd_top u_fpopd_top (.MCLK_I(clk), .RST_I(rst), .ISSUE_I(issue), .OP_I(op), .RS2_I(rs2),
		.RD_I(rd), .BUSY_O(busy), .AU_REQ_O(req), .AU_OP_O(aop), .AU_SRC_O(src),
		.AU_DONE_I(adone), .AU_RES_I(ares), .AU_EXC_I(aexc), .AU_FCC_I(afcc), .AU_CMPL_I(acmpl),
		.DONE_O(done), .RESULT_O(res), .EXC_O(exc), .FCC_O(fcc), .CMPL_O(cm),
		.LOAD_WE_I(we), .LOAD_ADDR_I(la), .LOAD_DATA_I(ld));
	fpopd_au_model u_fpopd_au_model (.clk_i(clk), .rst_i(rst), .req_i(req), .cmpl_i(mcmpl),
		.op_i(aop), .dly_i(dly), .src_i(src), .done_o(adone), .cmpl_o(acmpl), .res_o(ares),
		.exc_o(aexc), .fcc_o(afcc));
	// Compare one value
	task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] s);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Wait for a strobe at falling edges, bounded
	task automatic wait_hi(input bit sel);
		int n;
		n = 0;
		while ((sel ? done : req) !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
	endtask
	// Issue one op, check the gathered operands and returned answer
	task automatic run(input [4:0] o, input [4:0] s, input [4:0] d);
		logic [4:0] b;
		logic [95:0] e;
		b = nw(o) == 2'h1 ? s : nw(o) == 2'h2 ? {s[4:1], 1'b0} : {s[4:2], 2'h0};
		e = {mem[b], nw(o) > 2'h1 ? mem[b + 5'h1] : 32'h0, nw(o) > 2'h2 ? mem[b + 5'h2] : 32'h0};
		op = o;
		rs2 = s;
		rd = d;
		issue = 1'b1;
		@(negedge clk);
		issue = 1'b0;
		chk("busy", 96'h1, {95'h0, busy});
		wait_hi(1'b0);
		chk("request", 96'h1, {95'h0, req});
		chk("source", e, src);
		wait_hi(1'b1);
		chk("done", 96'h1, {95'h0, done});
		chk("busy", 96'h0, {95'h0, busy});
		chk("result", ~e, res);
		chk("exception", {91'h0, o == `FPOPD_OP_CMP ? 5'h00 : o}, {91'h0, exc});
		chk("ccode", {94'h0, o == `FPOPD_OP_CMP ? e[65:64] : 2'h0}, {94'h0, fcc});
		chk("complete", {95'h0, mcmpl}, {95'h0, cm});
		@(negedge clk);
	endtask
	// Every opcode with mixed delays and specifiers
	task automatic t_all;
		for (int i = 1; i <= 16; i++) begin
			dly = 4'(i % 4 + 1);
			run(5'(i), 5'h1F - 5'(i), 5'h00);
		end
		$display("t_all done");
	endtask
	// Completed double, extended and single results land in their registers and read back
	task automatic t_wb;
		mcmpl = 1'b1;
		run(`FPOPD_OP_I2D, 5'h03, 5'h0B);
		mem[10] = ~mem[3];
		mem[11] = 32'hFFFFFFFF;
		run(`FPOPD_OP_RTD, 5'h0B, 5'h00);
		run(`FPOPD_OP_I2X, 5'h05, 5'h16);
		mem[20] = ~mem[5];
		mem[21] = 32'hFFFFFFFF;
		mem[22] = 32'hFFFFFFFF;
		run(`FPOPD_OP_RTX, 5'h15, 5'h1C);
		run(`FPOPD_OP_D2S, 5'h07, 5'h19);
		mem[25] = ~mem[6];
		run(`FPOPD_OP_S2I, 5'h19, 5'h00);
		$display("t_wb done");
	endtask
	// Print counts and verdict, then stop
	task automatic final_report;
		$display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 32; i++) begin
			we = 1'b1;
			la = 5'(i);
			ld = 32'hC0DE0000 + 32'(i);
			mem[i] = ld;
			@(negedge clk);
		end
		we = 1'b0;
		t_all();
		t_wb();
		final_report();
	end
	// Watchdog
	initial begin
		#20000;
		fail_count++;
		final_report();
	end
endmodule
`default_nettype wire
